// ---- verilog/slsf_pkg.sv ----
// Package with offsets, field positions, codes and counts of the serial link status bank.
package slsf_pkg;
   // Clock and timeout unit.
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TO_UNIT_MS = 10;
   localparam int unsigned TO_UNIT_CYCLES = CLK_HZ / 1000 * TO_UNIT_MS;

   // Register byte offsets; per-channel registers sit one word apart.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CODE = 8'h08;
   localparam logic [7:0] OFF_COUNT = 8'h10;
   localparam logic [7:0] OFF_TMO = 8'h18;
   localparam logic [7:0] OFF_FMT = 8'h20;
   localparam logic [7:0] OFF_STN = 8'h28;
   localparam logic [7:0] OFF_INT_ST = 8'h30;
   localparam logic [7:0] OFF_INT_MASK = 8'h34;

   // Control register fields.
   localparam int CTRL_KEEP = 0;
   localparam int CTRL_UNIT = 1;
   localparam int CTRL_START = 4;

   // Status register fields, one bit per channel from each base.
   localparam int ST_COMM_ERR = 0;
   localparam int ST_GLOBAL = 2;
   localparam int ST_BUSY = 4;
   localparam int ST_OD_ERR = 6;

   // Interrupt event fields, four per channel.
   localparam int IEV_COMM_ERR = 0;
   localparam int IEV_GLOBAL = 1;
   localparam int IEV_OD_DONE = 2;
   localparam int IEV_OD_ERR = 3;

   // Error codes are the decimal figures 6301, 6305, 6306, 3801, 3805, 3806.
   localparam logic [15:0] ERR_PAR_CH1 = 16'h189d;
   localparam logic [15:0] ERR_CMD_CH1 = 16'h18a1;
   localparam logic [15:0] ERR_TMO_CH1 = 16'h18a2;
   localparam logic [15:0] ERR_PAR_CH2 = 16'h0ed9;
   localparam logic [15:0] ERR_CMD_CH2 = 16'h0edd;
   localparam logic [15:0] ERR_TMO_CH2 = 16'h0ede;

   // Largest on-demand item count accepted.
   localparam logic [15:0] OD_MAX_ITEMS = 16'h0040;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic keep;
      logic [1:0] unit_byte;
      logic [1:0] comm_err;
      logic [1:0][15:0] code;
      logic [1:0] gflag;
      logic [1:0] busy;
      logic [1:0] od_err;
      logic [1:0][15:0] od_count;
      logic [1:0][15:0] od_left;
      logic [1:0][15:0] tmo_set;
      logic [1:0][15:0] fmt;
      logic [1:0][15:0] stn;
      logic [1:0] rx_active;
      logic [1:0][31:0] pre;
      logic [1:0][15:0] units;
      logic [1:0] seq_rst;
      logic [7:0] int_st;
      logic [7:0] int_mask;
      logic irq;
      logic run_q;
      logic pwr_q;
   } slsf_state_s;
endpackage

// ---- verilog/slsf_top.sv ----
// Two-channel link status bank: error flags and codes, global flag, on-demand control.
// Operation
// - Per-channel sticky communication error flag.
// - Error flag set stores matching error code.
// - Error flag clears only on STOP to RUN.
// - Keep bit preserves format and station settings.
// - Global write command sets or clears global flag.
// - Global flag clears on power loss or STOP.
// - Busy set on send request, cleared when done.
// - Invalid data count sets on-demand error flag.
// - On-demand error blocks sending until cleared.
// - Unit bit: set bytes, clear words.
// - Word mode: one register per item.
// - Byte mode: registers are items halved, rounded up.
// - Line errors record 6301 or 3801.
// - Station FF non-global command records 6305 or 3805.
// - Receive timeout resets sequence, records 6306/3806.
// - Clearing flag keeps code; STOP to RUN clears.
//
// Decided for this implementation: the Wishbone register port and the address map.
module slsf_top #(
   parameter int unsigned TO_UNIT_CYCLES = slsf_pkg::TO_UNIT_CYCLES,
   parameter bit NEED_KEEP = 1'b1,
   parameter logic [15:0] MAX_ITEMS = slsf_pkg::OD_MAX_ITEMS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Controller mode
   input wire logic run_mode_i,
   input wire logic power_ok_i,
   // Receive side events, one bit per channel
   input wire logic [1:0] rx_char_i,
   input wire logic [1:0] rx_err_i,
   input wire logic [1:0] frame_done_i,
   input wire logic [1:0] station_ff_i,
   input wire logic [1:0] cmd_gw_i,
   input wire logic [1:0] gw_value_i,
   // On-demand transmit side and receive sequence reset
   input wire logic [1:0] tx_reg_done_i,
   output logic [1:0] ondemand_req_o,
   output logic [1:0] ondemand_byte_o,
   output logic [1:0][15:0] ondemand_regs_o,
   output logic [1:0] rx_seq_reset_o,
   // Interrupt
   output logic irq_o
);
   import slsf_pkg::*;

   slsf_state_s r_ff;
   slsf_state_s nxt_r;
   logic [1:0] start_ok;
   logic [1:0] ev_tmo;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      logic [15:0] m;
      m = old;
      if (sel[0]) begin
         m[7:0] = d[7:0];
      end
      if (sel[1]) begin
         m[15:8] = d[15:8];
      end
      return m;
   endfunction

   function automatic logic [15:0] err_code(input logic ch, input logic [1:0] kind);
      logic [15:0] v;
      v = 16'h0000;
      case (kind)
         2'h0: v = ch ? ERR_PAR_CH2 : ERR_PAR_CH1;
         2'h1: v = ch ? ERR_CMD_CH2 : ERR_CMD_CH1;
         default: v = ch ? ERR_TMO_CH2 : ERR_TMO_CH1;
      endcase
      return v;
   endfunction

   function automatic logic [7:0] ch_off(input logic [7:0] base, input logic ch);
      return base + {5'h00, ch, 2'h0};
   endfunction

   logic wr_en;
   logic [7:0] wa;
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & r_ff.ack;
   assign wa = {wb_adr_i[7:2], 2'h0};

   always_comb begin
      logic stop_to_run;
      logic run_to_stop;
      logic pwr_lost;
      logic ev_par;
      logic ev_cmd;
      logic ev_gw;
      logic [16:0] half;
      logic [7:0] iev;
      logic [15:0] cnt;
      stop_to_run = 1'b0;
      run_to_stop = 1'b0;
      pwr_lost = 1'b0;
      ev_par = 1'b0;
      ev_cmd = 1'b0;
      ev_gw = 1'b0;
      half = 17'h00000;
      iev = 8'h00;
      cnt = 16'h0000;
      nxt_r = r_ff;
      start_ok = 2'h0;
      ev_tmo = 2'h0;
      stop_to_run = run_mode_i & ~r_ff.run_q;
      run_to_stop = ~run_mode_i & r_ff.run_q;
      pwr_lost = ~power_ok_i & r_ff.pwr_q;
      nxt_r.run_q = run_mode_i;
      nxt_r.pwr_q = power_ok_i;

      // A write takes effect at the edge where the master sees ack high.
      nxt_r.ack = wb_cyc_i & wb_stb_i & ~r_ff.ack;
      if (wr_en && wa == OFF_CTRL) begin
         nxt_r.keep = wb_dat_i[CTRL_KEEP];
         nxt_r.unit_byte = wb_dat_i[CTRL_UNIT +: 2];
      end
      if (wr_en && wa == OFF_INT_MASK) begin
         nxt_r.int_mask = wb_dat_i[7:0];
      end

      for (int c = 0; c < 2; c++) begin
         ev_par = rx_err_i[c];
         ev_cmd = frame_done_i[c] & station_ff_i[c] & ~cmd_gw_i[c];
         ev_gw = frame_done_i[c] & station_ff_i[c] & cmd_gw_i[c];

         // Receive timeout: prescaled unit counter, restarted per character.
         if (rx_char_i[c]) begin
            nxt_r.rx_active[c] = 1'b1;
            nxt_r.pre[c] = 32'h00000000;
            nxt_r.units[c] = 16'h0000;
         end else if (frame_done_i[c]) begin
            nxt_r.rx_active[c] = 1'b0;
         end else if (r_ff.rx_active[c] && r_ff.tmo_set[c] != 16'h0000) begin
            if (r_ff.pre[c] == TO_UNIT_CYCLES - 1) begin
               nxt_r.pre[c] = 32'h00000000;
               nxt_r.units[c] = r_ff.units[c] + 16'h0001;
               if (r_ff.units[c] + 16'h0001 == r_ff.tmo_set[c]) begin
                  ev_tmo[c] = 1'b1;
                  nxt_r.rx_active[c] = 1'b0;
               end
            end else begin
               nxt_r.pre[c] = r_ff.pre[c] + 32'h00000001;
            end
         end
         nxt_r.seq_rst[c] = ev_tmo[c];

         // Flag and code survive recovery; only STOP to RUN clears them.
         if (stop_to_run) begin
            nxt_r.comm_err[c] = 1'b0;
            nxt_r.code[c] = 16'h0000;
         end
         // A new error in the same cycle as the clear wins.
         if (ev_par || ev_cmd || ev_tmo[c]) begin
            nxt_r.comm_err[c] = 1'b1;
            iev[c*4+IEV_COMM_ERR] = 1'b1;
            if (ev_par) begin
               nxt_r.code[c] = err_code(c[0], 2'h0);
            end else if (ev_cmd) begin
               nxt_r.code[c] = err_code(c[0], 2'h1);
            end else begin
               nxt_r.code[c] = err_code(c[0], 2'h2);
            end
         end

         if (run_to_stop || pwr_lost) begin
            nxt_r.gflag[c] = 1'b0;
         end
         if (ev_gw) begin
            nxt_r.gflag[c] = gw_value_i[c];
            iev[c*4+IEV_GLOBAL] = 1'b1;
         end

         // Settings are lost on power removal unless kept.
         if (pwr_lost && NEED_KEEP && !r_ff.keep) begin
            nxt_r.fmt[c] = 16'h0000;
            nxt_r.stn[c] = 16'h0000;
         end

         if (wr_en) begin
            if (wa == ch_off(OFF_COUNT, c[0])) begin
               nxt_r.od_count[c] = merge16(r_ff.od_count[c], wb_dat_i, wb_sel_i);
            end
            if (wa == ch_off(OFF_TMO, c[0])) begin
               nxt_r.tmo_set[c] = merge16(r_ff.tmo_set[c], wb_dat_i, wb_sel_i);
            end
            if (wa == ch_off(OFF_FMT, c[0])) begin
               nxt_r.fmt[c] = merge16(r_ff.fmt[c], wb_dat_i, wb_sel_i);
            end
            if (wa == ch_off(OFF_STN, c[0])) begin
               nxt_r.stn[c] = merge16(r_ff.stn[c], wb_dat_i, wb_sel_i);
            end
            if (wa == OFF_STATUS && wb_dat_i[ST_OD_ERR+c]) begin
               nxt_r.od_err[c] = 1'b0;
            end
         end

         // On-demand transfer: count registers down as the sender takes them.
         if (r_ff.busy[c] && tx_reg_done_i[c]) begin
            nxt_r.od_left[c] = r_ff.od_left[c] - 16'h0001;
            if (r_ff.od_left[c] == 16'h0001) begin
               nxt_r.busy[c] = 1'b0;
               iev[c*4+IEV_OD_DONE] = 1'b1;
            end
         end
         // A request while busy or while the error flag stands is dropped.
         if (wr_en && wa == OFF_CTRL && wb_dat_i[CTRL_START+c] && !r_ff.busy[c]
             && !r_ff.od_err[c]) begin
            cnt = r_ff.od_count[c];
            if (cnt == 16'h0000 || cnt > MAX_ITEMS) begin
               nxt_r.od_err[c] = 1'b1;
               iev[c*4+IEV_OD_ERR] = 1'b1;
            end else begin
               start_ok[c] = 1'b1;
               nxt_r.busy[c] = 1'b1;
               half = ({1'b0, cnt} + 17'h00001) >> 1;
               if (nxt_r.unit_byte[c]) begin
                  nxt_r.od_left[c] = half[15:0];
               end else begin
                  nxt_r.od_left[c] = cnt;
               end
            end
         end
      end

      if (wr_en && wa == OFF_INT_ST) begin
         nxt_r.int_st = r_ff.int_st & ~wb_dat_i[7:0];
      end
      nxt_r.int_st = nxt_r.int_st | iev;
      nxt_r.irq = |(nxt_r.int_st & nxt_r.int_mask);

      // Read data is latched with ack; unmapped addresses read zero.
      nxt_r.rdat = 32'h00000000;
      case (wa)
         OFF_CTRL: nxt_r.rdat = {29'h00000000, r_ff.unit_byte, r_ff.keep};
         OFF_STATUS: nxt_r.rdat = {24'h000000, r_ff.od_err, r_ff.busy, r_ff.gflag,
                                   r_ff.comm_err};
         OFF_CODE: nxt_r.rdat = {16'h0000, r_ff.code[0]};
         OFF_CODE + 8'h04: nxt_r.rdat = {16'h0000, r_ff.code[1]};
         OFF_COUNT: nxt_r.rdat = {16'h0000, r_ff.od_count[0]};
         OFF_COUNT + 8'h04: nxt_r.rdat = {16'h0000, r_ff.od_count[1]};
         OFF_TMO: nxt_r.rdat = {16'h0000, r_ff.tmo_set[0]};
         OFF_TMO + 8'h04: nxt_r.rdat = {16'h0000, r_ff.tmo_set[1]};
         OFF_FMT: nxt_r.rdat = {16'h0000, r_ff.fmt[0]};
         OFF_FMT + 8'h04: nxt_r.rdat = {16'h0000, r_ff.fmt[1]};
         OFF_STN: nxt_r.rdat = {16'h0000, r_ff.stn[0]};
         OFF_STN + 8'h04: nxt_r.rdat = {16'h0000, r_ff.stn[1]};
         OFF_INT_ST: nxt_r.rdat = {24'h000000, r_ff.int_st};
         OFF_INT_MASK: nxt_r.rdat = {24'h000000, r_ff.int_mask};
         default: nxt_r.rdat = 32'h00000000;
      endcase
      if (!(wb_cyc_i && wb_stb_i && !wb_we_i && !r_ff.ack)) begin
         nxt_r.rdat = r_ff.rdat;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign wb_dat_o = r_ff.rdat;
   assign wb_ack_o = r_ff.ack;
   assign ondemand_req_o = r_ff.busy;
   assign ondemand_byte_o = r_ff.unit_byte;
   assign ondemand_regs_o = r_ff.od_left;
   assign rx_seq_reset_o = r_ff.seq_rst;
   assign irq_o = r_ff.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_gw_frame0;
      frame_done_i[0] && station_ff_i[0] && cmd_gw_i[0];
   endsequence

   sequence s_cmd_err1;
      frame_done_i[1] && station_ff_i[1] && !cmd_gw_i[1] && !rx_err_i[1];
   endsequence

   AST_PAR_SETS_FLAG: assert property (rx_err_i[0] |=> r_ff.comm_err[0]
      && r_ff.code[0] == ERR_PAR_CH1) else $error("parity error not recorded on ch1");

   AST_FLAG_STICKY: assert property ((r_ff.comm_err[1] && !(run_mode_i && !r_ff.run_q))
      |=> r_ff.comm_err[1]) else $error("comm error flag dropped without STOP to RUN");

   AST_CODE_HOLDS: assert property ((!(run_mode_i && !r_ff.run_q) && !rx_err_i[0]
      && !frame_done_i[0] && !ev_tmo[0]) |=> $stable(r_ff.code[0]))
      else $error("error code changed without cause");

   AST_CMD_ERR_CH2: assert property (s_cmd_err1 |=> r_ff.code[1] == ERR_CMD_CH2)
      else $error("command error code wrong on ch2");

   AST_GLOBAL_STOP: assert property ((!run_mode_i && r_ff.run_q && !frame_done_i[0])
      |=> !r_ff.gflag[0]) else $error("global flag kept across STOP");

   AST_GLOBAL_SET: assert property (s_gw_frame0 ##0 gw_value_i[0] |=> r_ff.gflag[0])
      else $error("global write did not set flag");

   AST_BUSY_START: assert property (start_ok[0] |=> ondemand_req_o[0]
      ##0 (ondemand_byte_o[0] || ondemand_regs_o[0] == $past(r_ff.od_count[0])))
      else $error("busy or word count wrong after start");

   AST_BYTE_PACK: assert property (start_ok[1] && nxt_r.unit_byte[1] |=>
      ondemand_regs_o[1] == 16'((17'(r_ff.od_count[1]) + 17'h00001) >> 1))
      else $error("byte mode register count wrong");

   AST_OD_ERR_BLOCKS: assert property ((r_ff.od_err[1] && !r_ff.busy[1])
      |-> !start_ok[1]) else $error("send accepted with error flag set");

   AST_TIMEOUT_RESET: assert property (ev_tmo[1] |=> rx_seq_reset_o[1]
      && r_ff.code[1] != 16'h0000 ##1 !rx_seq_reset_o[1] || rx_char_i[1])
      else $error("timeout did not reset receive sequence");

   AST_IRQ_LEVEL: assert property (irq_o == |(r_ff.int_st & r_ff.int_mask))
      else $error("interrupt level mismatch");

   // Error capture on the channel not checked above for each case, with its own codes.
   sequence s_cmd_err0;
      frame_done_i[0] && station_ff_i[0] && !cmd_gw_i[0] && !rx_err_i[0];
   endsequence

   sequence s_gw_clear1;
      frame_done_i[1] && station_ff_i[1] && cmd_gw_i[1] && !gw_value_i[1];
   endsequence

   // A start with a count of zero or above the limit, while idle and free of errors.
   sequence s_bad_start1;
      wr_en && wa == OFF_CTRL && wb_dat_i[CTRL_START+1] && !r_ff.busy[1] && !r_ff.od_err[1]
         && (r_ff.od_count[1] == 16'h0000 || r_ff.od_count[1] > MAX_ITEMS);
   endsequence

   AST_PAR_CH2: assert property (rx_err_i[1] |=> r_ff.comm_err[1]
      && r_ff.code[1] == ERR_PAR_CH2) else $error("parity error not recorded on ch2");

   AST_CMD_ERR_CH1: assert property (s_cmd_err0 |=> r_ff.code[0] == ERR_CMD_CH1)
      else $error("command error code wrong on ch1");

   AST_TMO_CODE_CH1: assert property ((ev_tmo[0] && !rx_err_i[0]) |=> r_ff.comm_err[0]
      && r_ff.code[0] == ERR_TMO_CH1) else $error("timeout code not recorded on ch1");

   AST_STOP_RUN_CLEARS: assert property ((run_mode_i && !r_ff.run_q && !rx_err_i[0]
      && !frame_done_i[0] && !ev_tmo[0]) |=> !r_ff.comm_err[0] && r_ff.code[0] == 16'h0000)
      else $error("STOP to RUN did not clear flag and code");

   AST_GLOBAL_CLEAR: assert property (s_gw_clear1 |=> !r_ff.gflag[1])
      else $error("global write did not clear flag");

   AST_PWR_GLOBAL: assert property ((!power_ok_i && r_ff.pwr_q && !frame_done_i[0])
      |=> !r_ff.gflag[0]) else $error("global flag kept across power loss");

   // Any bus write is left out, so only the power path is watched here.
   AST_KEEP_SETTINGS: assert property ((r_ff.keep && !wr_en) |=> $stable(r_ff.fmt[0])
      && $stable(r_ff.stn[0])) else $error("kept settings changed without a write");

   AST_BUSY_DONE: assert property ((r_ff.busy[0] && tx_reg_done_i[0]
      && r_ff.od_left[0] == 16'h0001) |=> !ondemand_req_o[0])
      else $error("busy stayed set after the last register");

   AST_OD_ERR_SET: assert property (s_bad_start1 |=> r_ff.od_err[1] && !ondemand_req_o[1])
      else $error("invalid count did not raise the on-demand error");

   AST_TMO_RESTART: assert property (rx_char_i[1] |=> r_ff.rx_active[1]
      && r_ff.pre[1] == 32'h00000000 && r_ff.units[1] == 16'h0000)
      else $error("receive timer not restarted by a character");
endmodule

// ---- tb/slsf_host_model.sv ----
// Far-side sender model: it consumes one data register per pulse while a send is pending.
module slsf_host_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Pending sends and pace
   input wire logic [1:0] req_i,
   input wire logic slow_i,
   // One pulse per data register taken
   output logic [1:0] done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt [2];

   // The gap of at least three cycles lets busy fall before another pulse could come.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= '{0, 0};
         done_o <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            done_o[c] <= 1'b0;
            if (!req_i[c] || done_o[c]) begin
               cnt[c] <= 0;
            end else if (cnt[c] == (slow_i ? 6 : 2)) begin
               cnt[c] <= 0;
               done_o[c] <= 1'b1;
            end else begin
               cnt[c] <= cnt[c] + 1;
            end
         end
      end
   end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the link status bank with a far-side sender model.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import slsf_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b1, pwr = 1'b1, slow = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, seed = 32'hbb79437c;
   logic [1:0] rx_char = 2'b00, rx_err = 2'b00, fdone = 2'b00;
   logic [1:0] sff = 2'b00, cgw = 2'b00, gwv = 2'b00;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq_o;
   logic [1:0] ondemand_req_o, ondemand_byte_o, rx_seq, tx_done;
   logic [1:0][15:0] ondemand_regs_o;
   int fail_count = 0, checked = 0, cyc_n = 0, seq_n = 0, s0;

   slsf_top #(.TO_UNIT_CYCLES(4)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_mode_i(run),
      .power_ok_i(pwr), .rx_char_i(rx_char), .rx_err_i(rx_err), .frame_done_i(fdone),
      .station_ff_i(sff), .cmd_gw_i(cgw), .gw_value_i(gwv), .tx_reg_done_i(tx_done),
      .ondemand_req_o(ondemand_req_o), .ondemand_byte_o(ondemand_byte_o),
      .ondemand_regs_o(ondemand_regs_o), .rx_seq_reset_o(rx_seq), .irq_o(irq_o));
   slsf_host_model host (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(ondemand_req_o),
      .slow_i(slow), .done_o(tx_done));

   always #25 clk_i = ~clk_i;

   task automatic end_sim();
      $display("mismatches %0d checks %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The ceiling is several times the longest run of sends the sequence can make.
   always @(posedge clk_i) begin
      cyc_n++;
      seq_n += $countones(rx_seq);
      if (cyc_n == 40000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %0t got %h want %h", $time, g, e);
      end
   endtask

   // The wait for ack has no limit of its own; the cycle ceiling ends a hang.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      chk(32'(wb_ack_o), 32'h0);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic frm(input int c, input logic f, input logic g, input logic v);
      @(posedge clk_i);
      fdone <= 2'b01 << c;
      sff <= {2{f}};
      cgw <= {2{g}};
      gwv <= {2{v}};
      @(posedge clk_i);
      fdone <= 2'b00;
   endtask

   task automatic pls(input logic e, input int c);
      @(posedge clk_i);
      if (e) rx_err <= 2'b01 << c;
      else rx_char <= 2'b01 << c;
      @(posedge clk_i);
      rx_err <= 2'b00;
      rx_char <= 2'b00;
   endtask

   // Drops run mode (p low) or power (p high) for two cycles, then restores it.
   task automatic toggle(input logic p);
      @(posedge clk_i);
      if (p) pwr <= 1'b0;
      else run <= 1'b0;
      repeat (2) @(posedge clk_i);
      if (p) pwr <= 1'b1;
      else run <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [15:0] exp_regs(input logic [15:0] n, input logic b);
      return b ? (n + 16'h0001) >> 1 : n;
   endfunction

   task automatic od(input int c, input logic b, input logic [15:0] n);
      int k, t;
      k = 0;
      t = 0;
      wb(1'b1, OFF_COUNT + 8'(4 * c), 32'(n));
      wb(1'b1, OFF_CTRL, (32'(b) << (CTRL_UNIT + c)) | (32'h1 << (CTRL_START + c)));
      @(posedge clk_i);
      @(negedge clk_i);
      chk(32'(ondemand_req_o[c]), 32'h1);
      chk(32'(ondemand_byte_o[c]), 32'(b));
      chk(32'(ondemand_regs_o[c]), 32'(exp_regs(n, b)));
      while (ondemand_req_o[c] === 1'b1 && t < 3000) begin
         @(posedge clk_i);
         k += tx_done[c];
         t++;
      end
      chk(32'(k), 32'(exp_regs(n, b)));
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(OFF_STATUS);
      chk(q, 32'h0);
      rd(8'h3c);
      chk(q, 32'h0);
      wb(1'b1, OFF_INT_MASK, 32'h1);
      for (int c = 0; c < 2; c++) begin
         wb(1'b1, OFF_INT_ST, 32'hff);
         pls(1'b1, c);
         rd(OFF_STATUS);
         chk(q & 32'h3, 32'h1 << c);
         chk(32'(irq_o), 32'(c == 0));
         rd(OFF_CODE + 8'(4 * c));
         chk(q, 32'(c ? ERR_PAR_CH2 : ERR_PAR_CH1));
         wb(1'b1, OFF_INT_ST, 32'hff);
         @(posedge clk_i);
         @(negedge clk_i);
         chk(32'(irq_o), 32'h0);
         frm(c, 1'b0, 1'b0, 1'b0);
         rd(OFF_STATUS);
         chk(q & 32'h3, 32'h1 << c);
         toggle(1'b0);
         rd(OFF_STATUS);
         chk(q & 32'h3, 32'h0);
         rd(OFF_CODE + 8'(4 * c));
         chk(q, 32'h0);
         frm(c, 1'b1, 1'b0, 1'b0);
         rd(OFF_CODE + 8'(4 * c));
         chk(q, 32'(c ? ERR_CMD_CH2 : ERR_CMD_CH1));
         frm(c, 1'b1, 1'b1, 1'b1);
         rd(OFF_STATUS);
         chk(q & 32'hf, 32'h5 << c);
         frm(c, 1'b1, 1'b1, 1'b0);
         rd(OFF_STATUS);
         chk(q & 32'hc, 32'h0);
         frm(c, 1'b1, 1'b1, 1'b1);
         toggle(1'b0);
         rd(OFF_STATUS);
         chk(q & 32'hf, 32'h0);
         wb(1'b1, OFF_TMO + 8'(4 * c), 32'h1);
         s0 = seq_n;
         repeat (5) pls(1'b0, c);
         rd(OFF_STATUS);
         chk(q & 32'h3, 32'h0);
         repeat (12) @(posedge clk_i);
         rd(OFF_CODE + 8'(4 * c));
         chk(q, 32'(c ? ERR_TMO_CH2 : ERR_TMO_CH1));
         chk(32'(seq_n - s0), 32'h1);
         wb(1'b1, OFF_TMO + 8'(4 * c), 32'h0);
         toggle(1'b0);
      end
      wb(1'b1, OFF_FMT, 32'h1234);
      frm(0, 1'b1, 1'b1, 1'b1);
      toggle(1'b1);
      rd(OFF_FMT);
      chk(q, 32'h0);
      rd(OFF_STATUS);
      chk(q & 32'h4, 32'h0);
      wb(1'b1, OFF_CTRL, 32'h1);
      wb(1'b1, OFF_FMT, 32'h1234);
      toggle(1'b1);
      rd(OFF_FMT);
      chk(q, 32'h1234);
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, OFF_COUNT + 8'h04, i ? 32'(OD_MAX_ITEMS) + 32'h1 : 32'h0);
         wb(1'b1, OFF_CTRL, 32'h20);
         rd(OFF_STATUS);
         chk(q & 32'hf0, 32'h80);
         wb(1'b1, OFF_COUNT + 8'h04, 32'h3);
         wb(1'b1, OFF_CTRL, 32'h20);
         rd(OFF_STATUS);
         chk(q & 32'hf0, 32'h80);
         wb(1'b1, OFF_STATUS, 32'h80);
      end
      od(1, 1'b1, 16'h0005);
      od(0, 1'b0, OD_MAX_ITEMS);
      od(1, 1'b1, 16'h0001);
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         slow <= seed[3];
         od(int'(seed[0]), seed[1], 16'(seed[9:4]) + 16'h0001);
      end
      end_sim();
   end
endmodule
